// ---- adc_output_format_control_bench.sv ----
// Self-checking bench for the output format register bank and sample path
`timescale 1ns/1ps
`default_nettype none
`include "aof_defines.svh"

module adc_output_format_control_bench;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0, sv = 0, sysref = 1, lock = 0, single = 0;
  logic [11:0] addr = 0;
  logic [7:0]  wdata = 0, rdata;
  logic [15:0] sa = 0, sb = 0, da, db, ra, rb;
  logic [3:0]  tm = 0, band;
  logic [2:0]  ca, cb, rca, rcb;
  logic        ov, irq;
  int          num_errors = 0, checked = 0;
  logic [11:0] ad [8] = '{`AOF_ADDR_PAT4_LO, `AOF_ADDR_PAT4_HI, `AOF_ADDR_SEL_A, `AOF_ADDR_SEL_B,
                          `AOF_ADDR_FMT, `AOF_ADDR_CHAN, `AOF_ADDR_PLL_CFG, `AOF_ADDR_PLL_STATE};
  logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wm [8] = '{8'hff, 8'hff, 8'h77, 8'h07, 8'h07, 8'h03, 8'hf0, 8'h00};
  logic [3:0]  bc [4] = '{4'h0, 4'h1, 4'h3, 4'h5};
  logic [15:0] pw [4] = '{16'h1111, 16'h2222, 16'h3333, 16'habcd};

  // Clock of 100 ns period
  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and receiver; flags fixed so each source code gives a known bit per channel
  aof_output_format aof_output_format_i (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sample_valid(sv), .i_sample_a(sa), .i_sample_b(sb),
    .i_overrange(2'h1), .i_signal_monitor_flag(2'h2), .i_fast_detect_flag(2'h3), .i_sysref(sysref),
    .i_pll_lock(lock), .i_test_mode_sel(tm), .i_user_pattern_single(single), .i_user_pattern1(pw[0]),
    .i_user_pattern2(pw[1]), .i_user_pattern3(pw[2]), .o_valid(ov), .o_data_a(da), .o_data_b(db),
    .o_ctrl_a(ca), .o_ctrl_b(cb), .o_lane_rate_band(band), .o_irq(irq));
  aof_rx_model aof_rx_model_i (.i_core_clk(clk), .i_rstn(rstn), .i_valid(ov), .i_data_a(da), .i_data_b(db),
    .i_ctrl_a(ca), .i_ctrl_b(cb), .o_data_a(ra), .o_data_b(rb), .o_ctrl_a(rca), .o_ctrl_b(rcb));

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wrt(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are looked at there
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp("rdata", {8'h00, e}, {8'h00, rdata});
  endtask

  // One sample strobe, then one edge for the receiver to take the result
  task automatic smp(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    sa <= a;
    sb <= b;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    #2000000;
    num_errors++;
    wrap_up;
  end

  // Main sequence
  initial
  begin
    tk(20);
    rstn <= 1'b1;
    for (int k = 0; k < 8; k++) rdc(ad[k], rv[k]);
    for (int k = 0; k < 8; k++) wrt(ad[k], 8'hff);
    for (int k = 0; k < 8; k++) rdc(ad[k], wm[k]);
    wrt(12'h600, 8'hff);
    rdc(12'h600, 8'h00);
    // Write then read with no gap between the strobes
    @(posedge clk);
    addr  <= `AOF_ADDR_PAT4_LO;
    wdata <= 8'h5a;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp("rdata", 16'h005a, {8'h00, rdata});
    foreach (bc[k])
    begin
      wrt(`AOF_ADDR_PLL_CFG, {bc[k], 4'h0});
      tk(2);
      cmp("band", {12'h000, bc[k]}, {12'h000, band});
    end
    // Number format and invert, then channel swap
    wrt(`AOF_ADDR_CHAN, 8'h00);
    wrt(`AOF_ADDR_FMT, 8'h01);
    smp(16'h1234, 16'h8001);
    cmp("data_a", 16'h1234, ra);
    wrt(`AOF_ADDR_FMT, 8'h00);
    smp(16'h1234, 16'h8001);
    cmp("data_b", 16'h0001, rb);
    wrt(`AOF_ADDR_FMT, 8'h05);
    smp(16'h1234, 16'h8001);
    cmp("data_b", 16'h7ffe, rb);
    wrt(`AOF_ADDR_FMT, 8'h04);
    smp(16'h1234, 16'h8001);
    cmp("data_a", 16'h6dcb, ra);
    for (int c = 0; c < 8; c++)
    begin
      wrt(`AOF_ADDR_SEL_A, {1'b0, c[2:0], 1'b0, c[2:0]});
      wrt(`AOF_ADDR_SEL_B, {5'h00, c[2:0]});
      smp(16'h0000, 16'h0000);
      cmp("ctrl_a", {13'h0000, {3{c == 1 || c == 3 || c == 5}}}, {13'h0000, rca});
      cmp("ctrl_b", {13'h0000, {3{c == 2 || c == 3 || c == 5}}}, {13'h0000, rcb});
    end
    wrt(`AOF_ADDR_SEL_A, 8'h11);
    wrt(`AOF_ADDR_SEL_B, 8'h01);
    wrt(`AOF_ADDR_CHAN, 8'h01);
    smp(16'h1234, 16'h8001);
    cmp("data_a", 16'hfffe, ra);
    cmp("data_b", 16'h6dcb, rb);
    cmp("ctrl_pair", 16'h0007, {7'h00, rca, 3'h0, rcb});
    wrt(`AOF_ADDR_FMT, 8'h01);
    smp(16'h1234, 16'h8001);
    cmp("data_a", 16'h8001, ra);
    cmp("data_b", 16'h1234, rb);
    // User pattern, looped then single
    wrt(`AOF_ADDR_PAT4_LO, 8'hcd);
    wrt(`AOF_ADDR_PAT4_HI, 8'hab);
    for (int s = 0; s < 2; s++)
    begin
      single <= s[0];
      tm <= `AOF_TM_USER;
      for (int k = 0; k < 5; k++)
      begin
        smp(16'h0000, 16'h0000);
        cmp("pattern", (k == 4) ? (s == 1 ? 16'h0000 : pw[0]) : pw[k], ra);
      end
      @(posedge clk) tm <= 4'h0;
      tk(2);
    end
    // Interrupts: pattern end pending but masked, then lock
    rdc(`AOF_ADDR_IRQ_STAT, 8'h04);
    cmp("irq", 16'h0000, {15'h0000, irq});
    @(posedge clk) lock <= 1'b1;
    tk(10);
    rdc(`AOF_ADDR_PLL_STATE, 8'h80);
    rdc(`AOF_ADDR_IRQ_STAT, 8'h05);
    wrt(`AOF_ADDR_IRQ_MASK, 8'h01);
    tk(2);
    cmp("irq", 16'h0001, {15'h0000, irq});
    wrt(`AOF_ADDR_IRQ_STAT, 8'h01);
    tk(2);
    cmp("irq", 16'h0000, {15'h0000, irq});
    rdc(`AOF_ADDR_IRQ_STAT, 8'h04);
    // Loss of lock sets its own sticky bit
    @(posedge clk) lock <= 1'b0;
    tk(10);
    rdc(`AOF_ADDR_IRQ_STAT, 8'h06);
    cmp("irq", 16'h0000, {15'h0000, irq});
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- aof_ctrl_bit_mux.sv ----
// Source selector for one control bit carried with a sample
`timescale 1ns/1ps
`default_nettype none

module aof_ctrl_bit_mux
(
  input  wire logic [2:0] i_sel,
  input  wire logic       i_overrange,
  input  wire logic       i_signal_monitor_flag,
  input  wire logic       i_fast_detect_flag,
  input  wire logic       i_sysref,
  output logic            o_bit
);
  import aof_pkg::*;

  // Code 100 and the reserved codes fall to zero so nothing stray leaks out
  always_comb
  begin
    case (i_sel)
      AOF_SRC_OVR:      o_bit = i_overrange;
      AOF_SRC_SIG_MON:  o_bit = i_signal_monitor_flag;
      AOF_SRC_FAST_DET: o_bit = i_fast_detect_flag;
      AOF_SRC_SYSREF:   o_bit = i_sysref;
      default:          o_bit = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// ---- aof_defines.svh ----
// Register offsets, field positions, reset values and counts of the output format block
`ifndef AOF_DEFINES_SVH
`define AOF_DEFINES_SVH

// Register offsets
`define AOF_ADDR_PAT4_LO   12'h557
`define AOF_ADDR_PAT4_HI   12'h558
`define AOF_ADDR_SEL_A     12'h559
`define AOF_ADDR_SEL_B     12'h55a
`define AOF_ADDR_FMT       12'h561
`define AOF_ADDR_CHAN      12'h564
`define AOF_ADDR_PLL_CFG   12'h56e
`define AOF_ADDR_PLL_STATE 12'h56f
`define AOF_ADDR_IRQ_STAT  12'h5f0
`define AOF_ADDR_IRQ_MASK  12'h5f1

// Reset values
`define AOF_RST_ZERO  8'h00
`define AOF_RST_SEL_B 8'h01
`define AOF_RST_FMT   8'h01

// Writable bits of each register
`define AOF_WMASK_SEL_A 8'h77
`define AOF_WMASK_SEL_B 8'h07
`define AOF_WMASK_FMT   8'h07
`define AOF_WMASK_CHAN  8'h03
`define AOF_WMASK_PLL   8'hf0

// Field positions
`define AOF_SEL0_LSB   0
`define AOF_SEL1_LSB   4
`define AOF_SEL2_LSB   0
`define AOF_INV_BIT    2
`define AOF_FMT_LSB    0
`define AOF_SWAP_BIT   0
`define AOF_RATE_LSB   4
`define AOF_LOCK_BIT   7

// Test mode code that plays the user pattern words
`define AOF_TM_USER    4'h8
`define AOF_PAT_LAST   2'h3

// Interrupt status bits
`define AOF_IRQ_W      3
`define AOF_IRQ_LOCKED 0
`define AOF_IRQ_UNLOCK 1
`define AOF_IRQ_PATEND 2

`endif

// ---- aof_output_format.sv ----
// Register bank and sample formatter feeding the serial transport layer
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "aof_defines.svh"

module aof_output_format #(
  parameter int SAMPLE_W = 16
)
(
  input  wire logic                i_core_clk,
  input  wire logic                i_rstn,
  input  wire logic [11:0]         i_addr,
  input  wire logic [7:0]          i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [7:0]          o_rdata,
  input  wire logic                i_sample_valid,
  input  wire logic [SAMPLE_W-1:0] i_sample_a,
  input  wire logic [SAMPLE_W-1:0] i_sample_b,
  input  wire logic [1:0]          i_overrange,
  input  wire logic [1:0]          i_signal_monitor_flag,
  input  wire logic [1:0]          i_fast_detect_flag,
  input  wire logic                i_sysref,
  input  wire logic                i_pll_lock,
  input  wire logic [3:0]          i_test_mode_sel,
  input  wire logic                i_user_pattern_single,
  input  wire logic [15:0]         i_user_pattern1,
  input  wire logic [15:0]         i_user_pattern2,
  input  wire logic [15:0]         i_user_pattern3,
  output logic                     o_valid,
  output logic      [SAMPLE_W-1:0] o_data_a,
  output logic      [SAMPLE_W-1:0] o_data_b,
  output logic      [2:0]          o_ctrl_a,
  output logic      [2:0]          o_ctrl_b,
  output logic      [3:0]          o_lane_rate_band,
  output logic                     o_irq
);
  import aof_pkg::*;

  localparam logic [SAMPLE_W-1:0] MSB_MASK = {1'b1, {(SAMPLE_W-1){1'b0}}};

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]            user_pattern4_low,     next_user_pattern4_low;
  logic [7:0]            user_pattern4_high,    next_user_pattern4_high;
  logic [7:0]            control_bit_select_a,  next_control_bit_select_a;
  logic [7:0]            control_bit_select_b,  next_control_bit_select_b;
  logic [7:0]            sample_format_config,  next_sample_format_config;
  logic [7:0]            channel_order_config,  next_channel_order_config;
  logic [7:0]            serializer_pll_config, next_serializer_pll_config;
  logic [7:0]            serializer_pll_state,  next_serializer_pll_state;
  logic [`AOF_IRQ_W-1:0] irq_status,            next_irq_status;
  logic [`AOF_IRQ_W-1:0] irq_mask,              next_irq_mask;
  logic [`AOF_IRQ_W-1:0] irq_event;
  logic                  irq,                   next_irq;
  logic [7:0]            rdata,                 next_rdata;
  logic                  lock_prev;
  aof_pat_e              pat_state,             next_pat_state;
  logic [1:0]            pat_idx,               next_pat_idx;
  logic                  pat_done_ev;
  logic                  valid,                 next_valid;
  logic [SAMPLE_W-1:0]   data_a,                next_data_a;
  logic [SAMPLE_W-1:0]   data_b,                next_data_b;
  logic [2:0]            ctrl_a,                next_ctrl_a;
  logic [2:0]            ctrl_b,                next_ctrl_b;
  logic [1:0]            sync_lvl;
  logic                  sysref_lvl;
  logic                  lock_lvl;
  logic                  user_mode;
  logic                  swap;
  logic [2:0]            sel [3];
  logic [15:0]           pat_words [4];
  wire logic [2:0]       ctrl_raw [2];

  // Inverts and reformats one sample; core samples arrive as two's complement
  function automatic logic [SAMPLE_W-1:0] shape(input logic [SAMPLE_W-1:0] s,
                                                input logic                inv,
                                                input logic [1:0]          fmt);
    logic [SAMPLE_W-1:0] r;
    r = inv ? ~s : s;
    if (fmt == AOF_FMT_OFFSET)
    begin
      r = r ^ MSB_MASK;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin inputs: SYSREF and PLL lock come from outside this clock
  aof_pin_sync #(
    .W (2)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_async    ({i_pll_lock, i_sysref}),
    .o_level    (sync_lvl)
  );

  assign sysref_lvl = sync_lvl[0];
  assign lock_lvl   = sync_lvl[1];

  // Select fields and derived controls
  assign sel[0]    = control_bit_select_a[`AOF_SEL0_LSB +: 3];
  assign sel[1]    = control_bit_select_a[`AOF_SEL1_LSB +: 3];
  assign sel[2]    = control_bit_select_b[`AOF_SEL2_LSB +: 3];
  assign swap      = channel_order_config[`AOF_SWAP_BIT];
  assign user_mode = (i_test_mode_sel == `AOF_TM_USER);
  assign pat_words[0] = i_user_pattern1;
  assign pat_words[1] = i_user_pattern2;
  assign pat_words[2] = i_user_pattern3;
  assign pat_words[3] = {user_pattern4_high, user_pattern4_low};

  // One selector per channel and control bit; flags stay with their channel
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    for (genvar k = 0; k < 3; k++)
    begin : g_bit
      aof_ctrl_bit_mux u_mux (
        .i_sel                 (sel[k]),
        .i_overrange           (i_overrange[ch]),
        .i_signal_monitor_flag (i_signal_monitor_flag[ch]),
        .i_fast_detect_flag    (i_fast_detect_flag[ch]),
        .i_sysref              (sysref_lvl),
        .o_bit                 (ctrl_raw[ch][k])
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bank: writes, read mux, status and interrupts
  always_comb
  begin
    next_user_pattern4_low     = user_pattern4_low;
    next_user_pattern4_high    = user_pattern4_high;
    next_control_bit_select_a  = control_bit_select_a;
    next_control_bit_select_b  = control_bit_select_b;
    next_sample_format_config  = sample_format_config;
    next_channel_order_config  = channel_order_config;
    next_serializer_pll_config = serializer_pll_config;
    next_irq_mask              = irq_mask;
    next_irq_status            = irq_status;
    // Reserved bits are masked off so they always read zero
    if (i_wr)
    begin
      if (i_addr == `AOF_ADDR_PAT4_LO)
        next_user_pattern4_low = i_wdata;
      else if (i_addr == `AOF_ADDR_PAT4_HI)
        next_user_pattern4_high = i_wdata;
      else if (i_addr == `AOF_ADDR_SEL_A)
        next_control_bit_select_a = i_wdata & `AOF_WMASK_SEL_A;
      else if (i_addr == `AOF_ADDR_SEL_B)
        next_control_bit_select_b = i_wdata & `AOF_WMASK_SEL_B;
      else if (i_addr == `AOF_ADDR_FMT)
        next_sample_format_config = i_wdata & `AOF_WMASK_FMT;
      else if (i_addr == `AOF_ADDR_CHAN)
        next_channel_order_config = i_wdata & `AOF_WMASK_CHAN;
      else if (i_addr == `AOF_ADDR_PLL_CFG)
        next_serializer_pll_config = i_wdata & `AOF_WMASK_PLL;
      else if (i_addr == `AOF_ADDR_IRQ_STAT)
        next_irq_status = irq_status & ~i_wdata[`AOF_IRQ_W-1:0];
      else if (i_addr == `AOF_ADDR_IRQ_MASK)
        next_irq_mask = i_wdata[`AOF_IRQ_W-1:0];
    end
    // Lock status tracks the synchronised PLL lock level
    next_serializer_pll_state = `AOF_RST_ZERO;
    next_serializer_pll_state[`AOF_LOCK_BIT] = lock_lvl;
    // Events are ORed last so a set beats a clear in the same cycle
    irq_event = '0;
    irq_event[`AOF_IRQ_LOCKED] = lock_lvl & ~lock_prev;
    irq_event[`AOF_IRQ_UNLOCK] = ~lock_lvl & lock_prev;
    irq_event[`AOF_IRQ_PATEND] = pat_done_ev;
    next_irq_status = next_irq_status | irq_event;
    next_irq = |(next_irq_status & next_irq_mask);
    // Unmapped reads answer zero
    next_rdata = `AOF_RST_ZERO;
    if (i_rd)
    begin
      if (i_addr == `AOF_ADDR_PAT4_LO)
        next_rdata = user_pattern4_low;
      else if (i_addr == `AOF_ADDR_PAT4_HI)
        next_rdata = user_pattern4_high;
      else if (i_addr == `AOF_ADDR_SEL_A)
        next_rdata = control_bit_select_a;
      else if (i_addr == `AOF_ADDR_SEL_B)
        next_rdata = control_bit_select_b;
      else if (i_addr == `AOF_ADDR_FMT)
        next_rdata = sample_format_config;
      else if (i_addr == `AOF_ADDR_CHAN)
        next_rdata = channel_order_config;
      else if (i_addr == `AOF_ADDR_PLL_CFG)
        next_rdata = serializer_pll_config;
      else if (i_addr == `AOF_ADDR_PLL_STATE)
        next_rdata = serializer_pll_state;
      else if (i_addr == `AOF_ADDR_IRQ_STAT)
        next_rdata = {5'h00, irq_status};
      else if (i_addr == `AOF_ADDR_IRQ_MASK)
        next_rdata = {5'h00, irq_mask};
    end
  end

  // Register bank flops
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      user_pattern4_low     <= `AOF_RST_ZERO;
      user_pattern4_high    <= `AOF_RST_ZERO;
      control_bit_select_a  <= `AOF_RST_ZERO;
      control_bit_select_b  <= `AOF_RST_SEL_B;
      sample_format_config  <= `AOF_RST_FMT;
      channel_order_config  <= `AOF_RST_ZERO;
      serializer_pll_config <= `AOF_RST_ZERO;
      serializer_pll_state  <= `AOF_RST_ZERO;
      irq_status            <= '0;
      irq_mask              <= '0;
      irq                   <= 1'b0;
      rdata                 <= `AOF_RST_ZERO;
      lock_prev             <= 1'b0;
    end
    else
    begin
      user_pattern4_low     <= next_user_pattern4_low;
      user_pattern4_high    <= next_user_pattern4_high;
      control_bit_select_a  <= next_control_bit_select_a;
      control_bit_select_b  <= next_control_bit_select_b;
      sample_format_config  <= next_sample_format_config;
      channel_order_config  <= next_channel_order_config;
      serializer_pll_config <= next_serializer_pll_config;
      serializer_pll_state  <= next_serializer_pll_state;
      irq_status            <= next_irq_status;
      irq_mask              <= next_irq_mask;
      irq                   <= next_irq;
      rdata                 <= next_rdata;
      lock_prev             <= lock_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample path and user pattern player
  always_comb
  begin
    logic [SAMPLE_W-1:0] ch_a;
    logic [SAMPLE_W-1:0] ch_b;
    ch_a           = '0;
    ch_b           = '0;
    next_pat_state = pat_state;
    next_pat_idx   = pat_idx;
    pat_done_ev    = 1'b0;
    next_valid     = i_sample_valid;
    next_data_a    = data_a;
    next_data_b    = data_b;
    next_ctrl_a    = ctrl_a;
    next_ctrl_b    = ctrl_b;
    // Leaving user mode rewinds the player so the next entry starts at word one
    if (!user_mode)
    begin
      next_pat_state = AOF_PAT_IDLE;
      next_pat_idx   = 2'h0;
    end
    else if (i_sample_valid && pat_state != AOF_PAT_DONE)
    begin
      next_pat_state = AOF_PAT_RUN;
      next_pat_idx   = 2'(pat_idx + 2'h1);
      if (pat_idx == `AOF_PAT_LAST && i_user_pattern_single)
      begin
        next_pat_state = AOF_PAT_DONE;
        pat_done_ev    = 1'b1;
      end
    end
    // Data hold between samples; test words bypass the formatter
    if (i_sample_valid)
    begin
      ch_a = shape(i_sample_a, sample_format_config[`AOF_INV_BIT],
                   sample_format_config[`AOF_FMT_LSB +: 2]);
      ch_b = shape(i_sample_b, sample_format_config[`AOF_INV_BIT],
                   sample_format_config[`AOF_FMT_LSB +: 2]);
      if (user_mode)
      begin
        ch_a = (pat_state == AOF_PAT_DONE) ? '0 : SAMPLE_W'(pat_words[pat_idx]);
        ch_b = ch_a;
      end
      next_data_a = swap ? ch_b : ch_a;
      next_data_b = swap ? ch_a : ch_b;
      next_ctrl_a = swap ? ctrl_raw[1] : ctrl_raw[0];
      next_ctrl_b = swap ? ctrl_raw[0] : ctrl_raw[1];
    end
  end

  // Sample path flops
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      pat_state <= AOF_PAT_IDLE;
      pat_idx   <= 2'h0;
      valid     <= 1'b0;
      data_a    <= '0;
      data_b    <= '0;
      ctrl_a    <= 3'h0;
      ctrl_b    <= 3'h0;
    end
    else
    begin
      pat_state <= next_pat_state;
      pat_idx   <= next_pat_idx;
      valid     <= next_valid;
      data_a    <= next_data_a;
      data_b    <= next_data_b;
      ctrl_a    <= next_ctrl_a;
      ctrl_b    <= next_ctrl_b;
    end
  end

  assign o_rdata          = rdata;
  assign o_irq            = irq;
  assign o_valid          = valid;
  assign o_data_a         = data_a;
  assign o_data_b         = data_b;
  assign o_ctrl_a         = ctrl_a;
  assign o_ctrl_b         = ctrl_b;
  assign o_lane_rate_band = serializer_pll_config[`AOF_RATE_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  a_pat4_readback: assert property ((i_wr && i_addr == `AOF_ADDR_PAT4_LO) ##1
    (i_rd && i_addr == `AOF_ADDR_PAT4_LO) |=> o_rdata == $past(i_wdata, 2))
    else $error("pattern low byte did not read back");
  a_bit1_sysref: assert property ((i_sample_valid && sel[1] == AOF_SRC_SYSREF && !swap)
    |=> o_ctrl_a[1] == $past(sysref_lvl))
    else $error("control bit 1 does not carry sysref");
  a_bit0_low: assert property ((i_sample_valid && sel[0] == AOF_SRC_ZERO)
    |=> !o_ctrl_a[0] && !o_ctrl_b[0])
    else $error("control bit 0 not tied low");
  a_bit2_ovr: assert property ((i_sample_valid && sel[2] == AOF_SRC_OVR && !swap)
    |=> o_ctrl_b[2] == $past(i_overrange[1]))
    else $error("control bit 2 does not carry overrange");
  a_offset_fmt: assert property ((i_sample_valid && !user_mode && !swap
    && sample_format_config[2:0] == 3'h0) |=> o_data_a == ($past(i_sample_a) ^ MSB_MASK))
    else $error("offset binary output wrong");
  a_invert_twos: assert property ((i_sample_valid && !user_mode && !swap
    && sample_format_config[2:0] == 3'h5) |=> o_data_b == ~$past(i_sample_b))
    else $error("inverted output wrong");
  a_swap_order: assert property ((i_sample_valid && !user_mode && swap
    && sample_format_config[2:0] == 3'h1) |=> o_data_a == $past(i_sample_b))
    else $error("channel swap wrong");
  a_lock_read: assert property ((i_rd && i_addr == `AOF_ADDR_PLL_STATE)
    |=> o_rdata[7] == $past(lock_lvl, 2) && o_rdata[6:0] == 7'h00)
    else $error("lock status read wrong");
  a_single_stop: assert property ((i_sample_valid && user_mode && pat_state == AOF_PAT_DONE)
    |=> o_data_a == '0 && o_data_b == '0)
    else $error("single pattern kept playing");
  // Swap leaves the data words unchanged in user mode, and the word is taken as it stood at the strobe
  a_pat_words: assert property ((i_sample_valid && user_mode && pat_state != AOF_PAT_DONE
    && pat_idx == 2'h3) |=> o_data_a == SAMPLE_W'($past({user_pattern4_high, user_pattern4_low})))
    else $error("fourth pattern word wrong");
  a_reserved_zero: assert property ((i_sample_valid && sel[0] inside {3'h4, 3'h6, 3'h7})
    |=> !o_ctrl_a[0] && !o_ctrl_b[0])
    else $error("reserved select not zero");
  a_irq_level: assert property (o_irq == |(irq_status & irq_mask))
    else $error("interrupt level disagrees with status");

  c_single_done: cover property (pat_done_ev);
  c_swap_sample: cover property (i_sample_valid && swap && !user_mode);
  c_irq_raised: cover property ($rose(o_irq));
  c_loop_wrap: cover property (user_mode && !i_user_pattern_single && pat_idx == 2'h3 ##1 pat_idx == 2'h0);

endmodule

`default_nettype wire

// ---- aof_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none

module aof_pin_sync #(
  parameter int W = 1
)
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);
  import aof_pkg::*;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;
  logic [W-1:0] next_level;

  // A change counts only once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
    end
  end

  // Stage one feeds stage two alone
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign o_level = level;

endmodule

`default_nettype wire

// ---- aof_pkg.sv ----
// Types shared by the output format block
package aof_pkg;

  // Control bit source codes; unlisted codes act as zero
  typedef enum logic [2:0] {
    AOF_SRC_ZERO     = 3'h0,
    AOF_SRC_OVR      = 3'h1,
    AOF_SRC_SIG_MON  = 3'h2,
    AOF_SRC_FAST_DET = 3'h3,
    AOF_SRC_SYSREF   = 3'h5
  } aof_src_e;

  // Sample number formats
  typedef enum logic [1:0] {
    AOF_FMT_OFFSET = 2'h0,
    AOF_FMT_TWOS   = 2'h1
  } aof_fmt_e;

  // User pattern player, Gray coded
  typedef enum logic [1:0] {
    AOF_PAT_IDLE = 2'h0,
    AOF_PAT_RUN  = 2'h1,
    AOF_PAT_DONE = 2'h3
  } aof_pat_e;

endpackage

// ---- aof_rx_model.sv ----
// Receiver model that takes each formatted sample pair from the transport side
`timescale 1ns/1ps
`default_nettype none

module aof_rx_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_valid,
  input  wire logic [15:0] i_data_a,
  input  wire logic [15:0] i_data_b,
  input  wire logic [2:0]  i_ctrl_a,
  input  wire logic [2:0]  i_ctrl_b,
  output logic      [15:0] o_data_a,
  output logic      [15:0] o_data_b,
  output logic      [2:0]  o_ctrl_a,
  output logic      [2:0]  o_ctrl_b
);
  // Takes words only on valid, so a missing strobe leaves stale words that a compare catches
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      {o_data_a, o_data_b, o_ctrl_a, o_ctrl_b} <= '0;
    else if (i_valid)
      {o_data_a, o_data_b, o_ctrl_a, o_ctrl_b} <= {i_data_a, i_data_b, i_ctrl_a, i_ctrl_b};
  end
endmodule
`default_nettype wire
